// *** hw/dbf_pkg.sv ***
package dbf_pkg;

  // ****************************************************
  // Character and telegram layout
  // ****************************************************
  localparam logic [7:0] FRAME_START_CHAR = 8'h02;
  localparam int         CHAR_BITS        = 11;
  localparam logic [3:0] DATA_FIRST_IDX   = 4'h1;
  localparam logic [3:0] PARITY_IDX       = 4'h9;
  localparam logic [3:0] STOP_IDX         = 4'hA;
  localparam logic [7:0] LEN_OVERHEAD     = 8'h02;
  localparam logic [7:0] LEN_ONE_LEFT     = 8'h01;
  localparam logic [7:0] LEN_TWO_LEFT     = 8'h02;

  // ****************************************************
  // Address byte fields
  // ****************************************************
  localparam int         ADDR_LONG_BIT    = 7;
  localparam int         ADDR_BCAST_BIT   = 5;
  localparam int         ADDR_SHORT_MSB   = 4;
  localparam int         ADDR_LONG_MSB    = 6;
  localparam logic [6:0] ADDR_LONG_BCAST  = 7'h00;
  localparam logic [6:0] NODE_DEFAULT     = 7'h01;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          BAUD_DEFAULT     = 9600;
  localparam int          BAUD_MAX         = 115200;
  localparam int          MIN_BIT_CYCLES   = 4;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);

  // ****************************************************
  // States
  // ****************************************************
  typedef enum logic [2:0] {
    RX_HUNT, RX_LEN, RX_ADDR, RX_DATA, RX_CHECK
  } dbf_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE, TX_STX, TX_LEN, TX_ADDR, TX_DATA, TX_CHECK, TX_DRAIN
  } dbf_tx_e;

endpackage

// *** hw/dbf_buffer.sv ***
`timescale 1ns/100ps
module dbf_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("dbf_buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign inReady  = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and fill bookkeeping
  always_comb begin
    next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
    next_count = CW'(count + CW'(push) - CW'(pop));
  end

  // Head word is re-read every cycle so outData is a register;
  // a word written into the head slot bypasses the array
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
    if (push && (wrPtr == next_rdPtr)) begin
      outData <= inData;
    end else begin
      outData <= mem[next_rdPtr];
    end
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

endmodule

// *** hw/dbf_framer.sv ***
// Summary of operation
// [R01] Character: start, eight data, parity, stop
// [R02] Parity makes data plus parity even
// [R03] Telegram opens with start character 02h
// [R04] Length byte, then address byte follow
// [R05] Data bytes, then one closing check byte
// [R06] Length counts data, address and check
// [R07] Text telegrams need variable length support
// [R08] Address bit 7 selects short/long format
// [R09] Short: ignore bit 6, bit 5 broadcasts
// [R10] Long: match bits 0-6, zero broadcasts
// [R11] Echo received address byte unchanged
// [R12] Transmit only after being addressed
// [R13] Half-duplex; driver on only while sending
// [R14] One master, at most 126 slaves
// [R15] Short, long and text formats supported
// [R16] Node address and baud rate configurable
// [R17] Node addresses unique across all segments
// [R18] Check byte is XOR, starting from zero
// [R19] Bad or foreign telegram: no response
// [R20] Never answer a broadcast telegram
`timescale 1ns/100ps
module dbf_framer #(
  parameter int CLK_HZ = dbf_pkg::CLK_HZ
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        rxIn,
  output logic             txOut,
  output logic             txOeN,
  input  wire logic [6:0]  nodeAddr,
  input  wire logic [15:0] baudDiv,
  output logic      [7:0]  rxData,
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic             frameOk,
  output logic             frameErr,
  output logic             frameBcast,
  output logic             respAllowed,
  input  wire logic        respStart,
  input  wire logic [7:0]  respLen,
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  output logic             txBusy
);

  // Fastest baud must leave a few clocks per bit
  if (CLK_HZ / dbf_pkg::BAUD_MAX < dbf_pkg::MIN_BIT_CYCLES) begin : g_chk
    $error("dbf_framer clock too slow for the fastest baud rate");
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  // Returns {selected, broadcast}
  function automatic logic [1:0] addrSelect(input logic [7:0] a,
                                            input logic [6:0] node);
    logic [1:0] r;
    r = 2'b00;
    if (!a[dbf_pkg::ADDR_LONG_BIT]) begin // R08
      // Bit 6 plays no part in the short format
      if (a[dbf_pkg::ADDR_BCAST_BIT]) begin // R09
        r = 2'b11;
      end else if (7'(a[dbf_pkg::ADDR_SHORT_MSB:0]) == node) begin // R09
        r = 2'b10;
      end
    end else if (a[dbf_pkg::ADDR_LONG_MSB:0]
                 == dbf_pkg::ADDR_LONG_BCAST) begin // R10
      r = 2'b11;
    end else if (a[dbf_pkg::ADDR_LONG_MSB:0] == node) begin // R10
      r = 2'b10;
    end
    return r;
  endfunction

  // Start bit low, LSB first, even parity, stop high
  function automatic logic [10:0] charFrame(input logic [7:0] b);
    return {1'b1, ^b, b, 1'b0}; // R01 R02
  endfunction

  // ****************************************************
  // Line input synchroniser
  // ****************************************************
  logic rxMeta;
  logic rxSync;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxIn;
      rxSync <= rxMeta;
    end
  end

  // ****************************************************
  // Character receiver
  // ****************************************************
  logic        rxActive;
  logic [15:0] rxCnt;
  logic [3:0]  rxIdx;
  logic [7:0]  rxShift;
  logic        rxPar;
  logic        byteDone;
  logic        byteErr;
  logic        next_rxActive;
  logic [15:0] next_rxCnt;
  logic [3:0]  next_rxIdx;
  logic [7:0]  next_rxShift;
  logic        next_rxPar;
  logic        next_byteDone;
  logic        next_byteErr;

  // Samples at mid-bit; a start edge is ignored while we drive
  always_comb begin
    next_rxActive = rxActive;
    next_rxCnt    = rxCnt;
    next_rxIdx    = rxIdx;
    next_rxShift  = rxShift;
    next_rxPar    = rxPar;
    next_byteDone = 1'b0;
    next_byteErr  = 1'b0;
    if (!rxActive) begin
      // A start edge in the cycle a response is launched is left alone
      if (!rxSync && txOeN && !(respStart && respAllowed)) begin // R13
        next_rxActive = 1'b1;
        next_rxCnt    = baudDiv >> 1;
        next_rxIdx    = '0;
      end
    end else if (rxCnt != '0) begin
      next_rxCnt = rxCnt - 16'h0001;
    end else begin
      next_rxCnt = baudDiv - 16'h0001; // R16
      next_rxIdx = rxIdx + 4'h1;
      if (rxIdx == '0) begin
        // Glitch rather than a real start bit
        next_rxActive = !rxSync;
      end else if (rxIdx < dbf_pkg::PARITY_IDX) begin
        next_rxShift = {rxSync, rxShift[7:1]}; // R01
      end else if (rxIdx == dbf_pkg::PARITY_IDX) begin
        next_rxPar = rxSync;
      end else begin
        next_rxActive = 1'b0;
        next_byteDone = 1'b1;
        // Odd ones count or a missing stop bit spoils the byte
        next_byteErr  = (^{rxShift, rxPar}) || !rxSync; // R02 R01
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxActive <= 1'b0;
      rxCnt    <= '0;
      rxIdx    <= '0;
      rxShift  <= '0;
      rxPar    <= 1'b0;
      byteDone <= 1'b0;
      byteErr  <= 1'b0;
    end else begin
      rxActive <= next_rxActive;
      rxCnt    <= next_rxCnt;
      rxIdx    <= next_rxIdx;
      rxShift  <= next_rxShift;
      rxPar    <= next_rxPar;
      byteDone <= next_byteDone;
      byteErr  <= next_byteErr;
    end
  end

  // ****************************************************
  // Telegram receiver
  // ****************************************************
  dbf_pkg::dbf_rx_e rxState;
  dbf_pkg::dbf_rx_e next_rxState;
  logic [7:0]  rxRemain;
  logic [7:0]  rxCsum;
  logic [7:0]  rxAddr;
  logic        rxErrSeen;
  logic        rxSel;
  logic        rxBc;
  logic [7:0]  next_rxRemain;
  logic [7:0]  next_rxCsum;
  logic [7:0]  next_rxAddr;
  logic        next_rxErrSeen;
  logic        next_rxSel;
  logic        next_rxBc;
  logic        next_frameOk;
  logic        next_frameErr;
  logic        next_frameBcast;
  logic        next_respAllowed;
  logic [1:0]  sel;
  logic        bufPush;
  logic        bufReady;
  logic        respGo;

  assign sel     = addrSelect(rxShift, nodeAddr);
  assign bufPush = byteDone && (rxState == dbf_pkg::RX_DATA) && rxSel;

  always_comb begin
    next_rxState     = rxState;
    next_rxRemain    = rxRemain;
    next_rxCsum      = rxCsum ^ rxShift; // R18
    next_rxAddr      = rxAddr;
    next_rxErrSeen   = rxErrSeen || (byteDone && byteErr);
    next_rxSel       = rxSel;
    next_rxBc        = rxBc;
    next_frameOk     = 1'b0;
    next_frameErr    = 1'b0;
    next_frameBcast  = 1'b0;
    next_respAllowed = respAllowed && !respGo;
    if (!byteDone) begin
      next_rxCsum = rxCsum;
    end else begin
      case (rxState)
        dbf_pkg::RX_HUNT: begin
          if (!byteErr && rxShift == dbf_pkg::FRAME_START_CHAR) begin // R03
            next_rxState     = dbf_pkg::RX_LEN;
            next_rxCsum      = rxShift; // R18
            next_rxErrSeen   = 1'b0;
            next_respAllowed = 1'b0;
          end
        end
        dbf_pkg::RX_LEN: begin
          // Any length of at least address plus check is taken
          if (rxShift < dbf_pkg::LEN_OVERHEAD) begin // R07 R15
            next_rxState = dbf_pkg::RX_HUNT;
          end else begin
            next_rxState  = dbf_pkg::RX_ADDR; // R04
            next_rxRemain = rxShift - dbf_pkg::LEN_ONE_LEFT; // R06
          end
        end
        dbf_pkg::RX_ADDR: begin
          next_rxAddr  = rxShift;
          next_rxSel   = sel[1];
          next_rxBc    = sel[0];
          next_rxState = (rxRemain == dbf_pkg::LEN_ONE_LEFT)
                         ? dbf_pkg::RX_CHECK : dbf_pkg::RX_DATA; // R05
        end
        dbf_pkg::RX_DATA: begin
          // Overrun spoils the telegram rather than hide a gap
          if (bufPush && !bufReady) begin
            next_rxErrSeen = 1'b1;
          end
          next_rxRemain = rxRemain - dbf_pkg::LEN_ONE_LEFT;
          if (rxRemain == dbf_pkg::LEN_TWO_LEFT) begin
            next_rxState = dbf_pkg::RX_CHECK; // R05 R06
          end
        end
        dbf_pkg::RX_CHECK: begin
          next_rxState = dbf_pkg::RX_HUNT;
          if (rxSel) begin
            if (!rxErrSeen && !byteErr && rxShift == rxCsum) begin // R18
              next_frameOk     = 1'b1;
              next_frameBcast  = rxBc;
              next_respAllowed = !rxBc; // R12 R20
            end else begin
              next_frameErr = 1'b1; // R19
            end
          end
        end
        default: begin
          next_rxState = dbf_pkg::RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxState     <= dbf_pkg::RX_HUNT;
      rxRemain    <= '0;
      rxCsum      <= '0;
      rxAddr      <= '0;
      rxErrSeen   <= 1'b0;
      rxSel       <= 1'b0;
      rxBc        <= 1'b0;
      frameOk     <= 1'b0;
      frameErr    <= 1'b0;
      frameBcast  <= 1'b0;
      respAllowed <= 1'b0;
    end else begin
      rxState     <= next_rxState;
      rxRemain    <= next_rxRemain;
      rxCsum      <= next_rxCsum;
      rxAddr      <= next_rxAddr;
      rxErrSeen   <= next_rxErrSeen;
      rxSel       <= next_rxSel;
      rxBc        <= next_rxBc;
      frameOk     <= next_frameOk;
      frameErr    <= next_frameErr;
      frameBcast  <= next_frameBcast;
      respAllowed <= next_respAllowed;
    end
  end

  // Data bytes of selected telegrams; two words ride out a stall
  dbf_buffer #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_rxBuf (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inData   (rxShift),
    .inValid  (bufPush),
    .inReady  (bufReady),
    .outData  (rxData),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  // ****************************************************
  // Response transmitter
  // ****************************************************
  dbf_pkg::dbf_tx_e txState;
  dbf_pkg::dbf_tx_e next_txState;
  logic [7:0]  txLeft;
  logic [7:0]  txLenReg;
  logic [7:0]  txCsum;
  logic [10:0] txSh;
  logic [3:0]  txBitIdx;
  logic [15:0] txCnt;
  logic        txShBusy;
  logic [7:0]  next_txLeft;
  logic [7:0]  next_txLenReg;
  logic [7:0]  next_txCsum;
  logic [10:0] next_txSh;
  logic [3:0]  next_txBitIdx;
  logic [15:0] next_txCnt;
  logic        next_txShBusy;
  logic        next_txOut;
  logic        next_txOeN;
  logic        txLoad;
  logic [7:0]  txByte;

  // Only an addressed, quiet link may be answered
  assign respGo  = respStart && respAllowed && !rxActive
                   && (txState == dbf_pkg::TX_IDLE); // R12 R13
  assign txReady = (txState == dbf_pkg::TX_DATA) && !txShBusy;
  assign txBusy  = !txOeN;

  always_comb begin
    case (txState)
      dbf_pkg::TX_STX:   txByte = dbf_pkg::FRAME_START_CHAR; // R03
      dbf_pkg::TX_LEN:   txByte = txLenReg + dbf_pkg::LEN_OVERHEAD; // R06
      dbf_pkg::TX_ADDR:  txByte = rxAddr; // R11
      dbf_pkg::TX_CHECK: txByte = txCsum; // R18
      default:           txByte = txData;
    endcase
    txLoad = !txShBusy && (txState != dbf_pkg::TX_IDLE)
             && (txState != dbf_pkg::TX_DRAIN)
             && ((txState != dbf_pkg::TX_DATA) || txValid);
  end

  always_comb begin
    next_txState  = txState;
    next_txLeft   = txLeft;
    next_txLenReg = txLenReg;
    next_txCsum   = txCsum;
    next_txSh     = txSh;
    next_txBitIdx = txBitIdx;
    next_txCnt    = txCnt;
    next_txShBusy = txShBusy;
    next_txOut    = txOut;
    next_txOeN    = txOeN;
    if (respGo) begin
      next_txState  = dbf_pkg::TX_STX;
      next_txLenReg = respLen;
      next_txLeft   = respLen;
      next_txCsum   = '0; // R18
      next_txOeN    = 1'b0; // R13
    end
    if (txLoad) begin
      next_txCsum   = txCsum ^ txByte; // R18
      next_txSh     = charFrame(txByte);
      next_txOut    = 1'b0; // R01
      next_txBitIdx = '0;
      next_txCnt    = baudDiv - 16'h0001;
      next_txShBusy = 1'b1;
      case (txState)
        dbf_pkg::TX_STX:  next_txState = dbf_pkg::TX_LEN; // R04
        dbf_pkg::TX_LEN:  next_txState = dbf_pkg::TX_ADDR;
        dbf_pkg::TX_ADDR: next_txState = (txLeft == '0)
                          ? dbf_pkg::TX_CHECK : dbf_pkg::TX_DATA;
        dbf_pkg::TX_DATA: begin
          next_txLeft  = txLeft - 8'h01;
          next_txState = (txLeft == 8'h01)
                         ? dbf_pkg::TX_CHECK : dbf_pkg::TX_DATA; // R05
        end
        default:          next_txState = dbf_pkg::TX_DRAIN;
      endcase
    end else if (txShBusy) begin
      if (txCnt != '0) begin
        next_txCnt = txCnt - 16'h0001;
      end else if (txBitIdx == dbf_pkg::STOP_IDX) begin
        next_txShBusy = 1'b0;
        next_txOut    = 1'b1;
      end else begin
        next_txCnt    = baudDiv - 16'h0001;
        next_txBitIdx = txBitIdx + 4'h1;
        next_txSh     = txSh >> 1;
        next_txOut    = txSh[1];
      end
    end else if (txState == dbf_pkg::TX_DRAIN) begin
      // Release the driver once the check byte's stop bit ends
      next_txState = dbf_pkg::TX_IDLE;
      next_txOeN   = 1'b1; // R13
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txState  <= dbf_pkg::TX_IDLE;
      txLeft   <= '0;
      txLenReg <= '0;
      txCsum   <= '0;
      txSh     <= '1;
      txBitIdx <= '0;
      txCnt    <= '0;
      txShBusy <= 1'b0;
      txOut    <= 1'b1;
      txOeN    <= 1'b1;
    end else begin
      txState  <= next_txState;
      txLeft   <= next_txLeft;
      txLenReg <= next_txLenReg;
      txCsum   <= next_txCsum;
      txSh     <= next_txSh;
      txBitIdx <= next_txBitIdx;
      txCnt    <= next_txCnt;
      txShBusy <= next_txShBusy;
      txOut    <= next_txOut;
      txOeN    <= next_txOeN;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  property p_evenParity;
    @(posedge sys_clk) disable iff (rst)
    txLoad |=> !txOut && (^txSh[9:1] == 1'b0) && txSh[10];
  endproperty
  a_evenParity: assert property (p_evenParity) // R02
    else $error("bad character framing or parity");

  property p_charEnds;
    @(posedge sys_clk) disable iff (rst)
    $fell(txShBusy) |-> $past(txBitIdx) == dbf_pkg::STOP_IDX && txOut;
  endproperty
  a_charEnds: assert property (p_charEnds) // R01
    else $error("character did not last eleven bits");

  property p_stxFirst;
    @(posedge sys_clk) disable iff (rst)
    respGo |=> txLoad && txByte == dbf_pkg::FRAME_START_CHAR;
  endproperty
  a_stxFirst: assert property (p_stxFirst) // R03
    else $error("response did not open with start character");

  property p_lenByte;
    @(posedge sys_clk) disable iff (rst)
    txLoad && txState == dbf_pkg::TX_LEN
      |-> txByte == 8'($past(txLenReg) + dbf_pkg::LEN_OVERHEAD);
  endproperty
  a_lenByte: assert property (p_lenByte) // R06
    else $error("length byte wrong");

  property p_echoAddr;
    @(posedge sys_clk) disable iff (rst)
    txLoad && txState == dbf_pkg::TX_ADDR |=> txSh[8:1] == rxAddr;
  endproperty
  a_echoAddr: assert property (p_echoAddr) // R11
    else $error("address byte not echoed");

  property p_onlyWhenAsked;
    @(posedge sys_clk) disable iff (rst)
    $fell(txOeN) |-> $past(respAllowed) && $past(respStart);
  endproperty
  a_onlyWhenAsked: assert property (p_onlyWhenAsked) // R12
    else $error("transmission without being addressed");

  property p_halfDuplex;
    @(posedge sys_clk) disable iff (rst)
    (txOeN |-> txOut && !txShBusy) and (!txOeN |-> !rxActive);
  endproperty
  a_halfDuplex: assert property (p_halfDuplex) // R13
    else $error("driver and receiver overlap");

  property p_noBcastReply;
    @(posedge sys_clk) disable iff (rst)
    frameOk && frameBcast |-> !respAllowed ##1 !respAllowed;
  endproperty
  a_noBcastReply: assert property (p_noBcastReply) // R20
    else $error("broadcast answered");

  property p_errNoReply;
    @(posedge sys_clk) disable iff (rst)
    frameErr |-> !respAllowed && !frameOk;
  endproperty
  a_errNoReply: assert property (p_errNoReply) // R19
    else $error("faulty telegram may be answered");

endmodule

// *** verif/dbf_master.sv ***
`timescale 1ns/100ps
// ****************************************************
// Single bus master model
// ****************************************************
module dbf_master (
  input  wire logic        sys_clk,
  input  wire logic [15:0] bitLen,
  input  wire logic        txOut,
  input  wire logic        txOeN,
  output logic             line
);
  logic [7:0] rxQ[$];
  int         badChars;
  logic [10:0] f;

  // Sends one character, LSB first; flip breaks parity
  task automatic sendChar(input logic [7:0] b, input logic flip);
    logic [10:0] c;
    c = {1'b1, ^b ^ flip, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line = c[i];
      repeat (bitLen) @(negedge sys_clk);
    end
    line = 1'b1; // Biased line idles high when released
  endtask

  // Decodes answer characters mid-bit while the slave drives;
  // falling-edge sampling stays clear of the launching edge
  initial begin
    line = 1'b1;
    badChars = 0;
    forever begin
      @(negedge sys_clk);
      if (!txOeN && !txOut) begin
        repeat (bitLen / 2) @(negedge sys_clk);
        for (int i = 0; i < 11; i++) begin
          f[i] = txOut;
          if (i < 10) repeat (bitLen) @(negedge sys_clk);
        end
        if (f[0] || !f[10] || ^f[9:1]) badChars++;
        rxQ.push_back(f[8:1]);
      end
    end
  end
endmodule

// *** verif/drive_bus_telegram_framer_test.sv ***
`timescale 1ns/100ps
module drive_bus_telegram_framer_test;
  logic       sys_clk, rst, mLine, rxIn, txOut, txOeN, rxValid;
  logic       rxReady, frameOk, frameErr, frameBcast, respAllowed;
  logic       respStart, txValid, txReady, txBusy, hold;
  logic [6:0] nodeAddr;
  logic [15:0] baudDiv;
  logic [7:0] rxData, respLen, txData;
  logic [7:0] gotQ[$], txBuf[$];
  int         mismatches, totalChecks, oks, errs, bcs, cyc, seed, txIdx;

  // ****************************************************
  // Design, master and shared half-duplex wire
  // ****************************************************
  assign rxIn = txOeN ? mLine : txOut;
  dbf_master u_master (.sys_clk(sys_clk), .bitLen(baudDiv), .txOut(txOut),
                       .txOeN(txOeN), .line(mLine));
  dbf_framer u_dut (.sys_clk(sys_clk), .rst(rst), .rxIn(rxIn),
    .txOut(txOut), .txOeN(txOeN), .nodeAddr(nodeAddr),
    .baudDiv(baudDiv), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .frameOk(frameOk), .frameErr(frameErr),
    .frameBcast(frameBcast), .respAllowed(respAllowed),
    .respStart(respStart), .respLen(respLen), .txData(txData),
    .txValid(txValid), .txReady(txReady), .txBusy(txBusy));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Inputs change at the falling edge; stalls are random
  always @(negedge sys_clk) begin
    txValid = txIdx < txBuf.size();
    txData = txValid ? txBuf[txIdx] : 8'h00;
    rxReady = hold ? 1'b0 : 1'($random(seed));
  end

  // Observation and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxValid && rxReady) gotQ.push_back(rxData);
    if (txValid && txReady) txIdx <= txIdx + 1;
    oks <= oks + int'(frameOk);
    errs <= errs + int'(frameErr);
    bcs <= bcs + int'(frameBcast);
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // Reference: one request telegram and its expected outcome
  task automatic tel(input logic [7:0] adr, input int n, bad,
                     input logic chk, ovr);
    logic [7:0] t[$];
    logic [7:0] x;
    logic       sel, bc, good;
    t = {8'h02, 8'(n + 2), adr};
    for (int i = 0; i < n; i++) t.push_back(8'($random(seed)));
    x = 8'h00;
    foreach (t[i]) x ^= t[i];
    t.push_back(x ^ {7'h00, chk});
    bc = adr[7] ? adr[6:0] == 7'h00 : adr[5];
    sel = bc || (adr[7] ? adr[6:0] == nodeAddr
                        : {2'b00, adr[4:0]} == nodeAddr);
    good = sel && bad < 0 && !chk && !ovr;
    @(negedge sys_clk);
    oks = 0;
    errs = 0;
    bcs = 0;
    gotQ.delete();
    foreach (t[i]) u_master.sendChar(t[i], i == bad);
    repeat (20) @(negedge sys_clk);
    hold = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("frameOk", good, oks);
    check("frameErr", sel && !good, errs);
    check("frameBcast", good && bc, bcs);
    check("respAllowed", good && !bc, respAllowed);
    if (good || !sel) check("words", good ? n : 0, gotQ.size());
    if (good) foreach (gotQ[i]) check("rxData", t[i + 3], gotQ[i]);
  endtask

  // Response request; refused ones must leave the driver off
  task automatic respond(input int n, input logic [7:0] adr,
                         input logic ok);
    logic [7:0] e[$];
    txBuf.delete();
    txIdx = 0;
    e = {8'h02, 8'(n + 2), adr};
    for (int i = 0; i < n; i++) txBuf.push_back(8'($random(seed)));
    e = {e, txBuf};
    e.push_back(8'h00);
    for (int i = 0; i < n + 3; i++) e[n + 3] ^= e[i];
    u_master.rxQ.delete();
    u_master.badChars = 0;
    respLen = 8'(n);
    respStart = 1'b1;
    @(negedge sys_clk);
    respStart = 1'b0;
    @(negedge sys_clk);
    check("txBusy", ok, txBusy);
    for (int i = 0; i < 3000 && !txOeN; i++) @(negedge sys_clk);
    repeat (20) @(negedge sys_clk);
    check("chars", ok ? n + 4 : 0, u_master.rxQ.size());
    check("badChars", 0, u_master.badChars);
    if (ok) foreach (e[i]) check("txByte", e[i], u_master.rxQ[i]);
    check("respAllowed", 0, respAllowed);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    seed = 32'h54a5;
    {mismatches, totalChecks, oks, errs, bcs, cyc, txIdx} = '0;
    {hold, respStart, txValid, rxReady} = '0;
    respLen = 8'h00;
    txData = 8'h00;
    baudDiv = 16'h0008;
    nodeAddr = 7'h05;
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    tel(8'h05, 4, -1, 0, 0);
    respond(4, 8'h05, 1);
    respond(1, 8'h05, 0);
    tel(8'h45, 12, -1, 0, 0);
    respond(12, 8'h45, 1);
    tel(8'h85, 13, -1, 0, 0);
    respond(0, 8'h85, 1);
    tel(8'h3F, 4, -1, 0, 0);
    respond(1, 8'h3F, 0);
    tel(8'h06, 4, -1, 0, 0);
    tel(8'h05, 4, 5, 0, 0);
    tel(8'h05, 4, -1, 1, 0);
    hold = 1'b1;
    tel(8'h05, 6, -1, 0, 1);
    // Slower bit rate for the tail: two long-format telegrams, one short-format
    baudDiv = 16'h000C;
    nodeAddr = 7'h7E;
    tel(8'hFE, 4, -1, 0, 0);
    tel(8'h80, 4, -1, 0, 0);
    tel(8'h1E, 4, -1, 0, 0);
    summarize();
  end
endmodule
